// >>> bgsr_status_regs.v
// Buffer data, revision, identifier and operating state status registers
`timescale 1ns/1ns
`include "bgsr_consts.vh"
// Summary of operation
// - Big-endian: bits 11:4 first, 3:0 next
// - Big-endian second byte low nibble reads zero
// - Revision register: BCD major and minor
// - Identifier returns fixed code, never written
// - Gated overrun sets flag on unemptied buffer
// - Flag holds while buffer holds samples
// - Drain, flush, disable, standby-to-active clear flag
// - Five-bit counter counts periods since flag
// - Same four events clear period counter
// - Disable or activation also empties buffer
// - Mode bits report state; boot pin sets reset
// - Mode codes: standby, wake, sleep, triggered
// - Data shows oldest in FIFO, newest in LIFO
// - Samples are 12-bit two's complement
module bgsr_status_regs #(
   parameter DEPTH = `BGSR_DEPTH          // Buffer depth in triplets
) (
   input  wire        SYS_CLK_IN,         // System clock, 10 MHz
   input  wire        NRST_IN,            // Asynchronous reset, active low
   input  wire        BOOT_STATE_PIN_IN,  // Boot state strap
   input  wire        BYTE_ORDER_SELECT_IN, // 1 selects big-endian layout
   input  wire        LIFO_ORDER_IN,      // 1 selects newest-first readout
   input  wire        GATE_ENABLE_IN,     // Sample gating enable
   input  wire [1:0]  BUF_MODE_IN,        // Buffer mode, 00 disables
   input  wire        FLUSH_IN,           // Flush command pulse
   input  wire [1:0]  MODE_REQ_IN,        // Requested operating state
   input  wire        MODE_REQ_VALID_IN,  // Operating state change pulse
   input  wire        SAMPLE_VALID_IN,    // New XYZ sample pulse
   input  wire [11:0] SAMPLE_X_IN,        // X sample, two's complement
   input  wire [11:0] SAMPLE_Y_IN,        // Y sample, two's complement
   input  wire [11:0] SAMPLE_Z_IN,        // Z sample, two's complement
   input  wire        RD_EN_IN,           // Register read strobe
   input  wire [7:0]  RD_ADDR_IN,         // Register read address
   input  wire        POP_IN,             // Sample consumed pulse
   input  wire        WR_EN_IN,           // Register write strobe
   input  wire [7:0]  WR_ADDR_IN,         // Register write address
   input  wire [7:0]  WR_DATA_IN,         // Register write data
   output reg  [7:0]  RD_DATA_OUT,        // Register read data
   output reg         RD_VALID_OUT,       // Read data valid pulse
   output reg  [5:0]  FILL_OUT            // Samples held in buffer
);
   reg [4:0]  head;                       // Next write slot
   reg [4:0]  tail;                       // Oldest slot
   reg [5:0]  fill;                       // Current fill level
   reg [1:0]  op_state;                   // Operating state
   reg        overrun;                    // Gate overrun flag
   reg [4:0]  gate_cnt;                   // Gate overrun period count
   reg [1:0]  prev_buf_mode;              // Buffer mode last cycle
   reg        boot_done;                  // Strap captured
   reg [5:0]  next_fill;                  // Next fill level
   wire [35:0] mem_q;                     // Selected triplet
   wire [4:0]  rd_slot;                   // Slot shown in data registers
   wire        activating;                // Standby to active transition
   wire        disabling;                 // Buffer mode written to off
   wire        empty_evt;                 // Buffer emptied by command
   wire        push;                      // Sample accepted
   wire        pop;                       // Sample removed

   // Slot presented: oldest or newest
   assign rd_slot = LIFO_ORDER_IN ? (head - 5'h01) : tail;
   assign activating = MODE_REQ_VALID_IN && (op_state == `BGSR_MODE_STANDBY)
                       && (MODE_REQ_IN != `BGSR_MODE_STANDBY);
   assign disabling = (BUF_MODE_IN == `BGSR_BUF_OFF) && (prev_buf_mode != `BGSR_BUF_OFF);
   // Disable and activation empty the buffer
   assign empty_evt = FLUSH_IN || disabling || activating;
   assign push = SAMPLE_VALID_IN && (BUF_MODE_IN != `BGSR_BUF_OFF)
                 && !(GATE_ENABLE_IN && (fill != 6'h00)) && (fill != 6'h20);
   assign pop = POP_IN && (fill != 6'h00) && !push;

   // Triplet storage
   bgsr_sample_mem #(.DEPTH(DEPTH), .AW(5), .DW(36)) u_mem (
      .clk_in      (SYS_CLK_IN),
      .wr_en_in    (push),
      .wr_addr_in  (head),
      .wr_data_in  ({SAMPLE_Z_IN, SAMPLE_Y_IN, SAMPLE_X_IN}),
      .rd_addr_in  (rd_slot),
      .rd_data_out (mem_q)
   );

   // Byte lane for one axis in either order
   function [7:0] bgsr_axis_byte;
      input [11:0] s;
      input        big;
      input        second;
      begin
         if (big) begin
            // Upper bits first, low nibble left-justified, zero fill
            bgsr_axis_byte = second ? {s[3:0], 4'h0} : s[11:4];
         end else begin
            // Little-endian with sign extension
            bgsr_axis_byte = second ? {{4{s[11]}}, s[11:8]} : s[7:0];
         end
      end
   endfunction

   // Next fill level
   always @* begin
      next_fill = fill;
      if (empty_evt) begin
         next_fill = 6'h00;
      end else if (push) begin
         next_fill = fill + 6'h01;
      end else if (pop) begin
         next_fill = fill - 6'h01;
      end
   end

   // Buffer pointers and fill
   always @(posedge SYS_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         head <= 5'h00;
         tail <= 5'h00;
         fill <= 6'h00;
         FILL_OUT <= 6'h00;
         prev_buf_mode <= 2'h0;
      end else begin
         prev_buf_mode <= BUF_MODE_IN;
         fill <= next_fill;
         FILL_OUT <= next_fill;
         if (empty_evt) begin
            head <= 5'h00;
            tail <= 5'h00;
         end else if (push) begin
            head <= head + 5'h01;
         end else if (pop) begin
            if (LIFO_ORDER_IN) begin
               head <= head - 5'h01;
            end else begin
               tail <= tail + 5'h01;
            end
         end
      end
   end

   // Operating state; strap taken after reset release
   always @(posedge SYS_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         op_state  <= `BGSR_MODE_STANDBY;
         boot_done <= 1'b0;
      end else if (!boot_done) begin
         boot_done <= 1'b1;
         op_state  <= BOOT_STATE_PIN_IN ? `BGSR_MODE_WAKE : `BGSR_MODE_STANDBY;
      end else if (MODE_REQ_VALID_IN) begin
         op_state <= MODE_REQ_IN;
      end
   end

   // Gate overrun flag and period counter
   always @(posedge SYS_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         overrun  <= 1'b0;
         gate_cnt <= 5'h00;
      end else if (empty_evt || (next_fill == 6'h00)) begin
         overrun  <= 1'b0;
         gate_cnt <= 5'h00;
      end else if (SAMPLE_VALID_IN && GATE_ENABLE_IN && (fill != 6'h00)) begin
         overrun <= 1'b1;
         if (overrun) begin
            gate_cnt <= gate_cnt + 5'h01;
         end
      end
   end

   // Read decode; writes never touch this group
   always @(posedge SYS_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         RD_DATA_OUT  <= 8'h00;
         RD_VALID_OUT <= 1'b0;
      end else begin
         RD_VALID_OUT <= RD_EN_IN;
         if (!RD_EN_IN) begin
            RD_DATA_OUT <= RD_DATA_OUT;
         end else if (RD_ADDR_IN == `BGSR_ADDR_X_FIRST) begin
            RD_DATA_OUT <= bgsr_axis_byte(mem_q[11:0], BYTE_ORDER_SELECT_IN, 1'b0);
         end else if (RD_ADDR_IN == `BGSR_ADDR_X_SECOND) begin
            RD_DATA_OUT <= bgsr_axis_byte(mem_q[11:0], BYTE_ORDER_SELECT_IN, 1'b1);
         end else if (RD_ADDR_IN == `BGSR_ADDR_Y_FIRST) begin
            RD_DATA_OUT <= bgsr_axis_byte(mem_q[23:12], BYTE_ORDER_SELECT_IN, 1'b0);
         end else if (RD_ADDR_IN == `BGSR_ADDR_Y_SECOND) begin
            RD_DATA_OUT <= bgsr_axis_byte(mem_q[23:12], BYTE_ORDER_SELECT_IN, 1'b1);
         end else if (RD_ADDR_IN == `BGSR_ADDR_Z_FIRST) begin
            RD_DATA_OUT <= bgsr_axis_byte(mem_q[35:24], BYTE_ORDER_SELECT_IN, 1'b0);
         end else if (RD_ADDR_IN == `BGSR_ADDR_Z_SECOND) begin
            RD_DATA_OUT <= bgsr_axis_byte(mem_q[35:24], BYTE_ORDER_SELECT_IN, 1'b1);
         end else if (RD_ADDR_IN == `BGSR_ADDR_REVISION) begin
            RD_DATA_OUT <= {`BGSR_REV_MAJOR, `BGSR_REV_MINOR};
         end else if (RD_ADDR_IN == `BGSR_ADDR_PART_ID) begin
            RD_DATA_OUT <= `BGSR_PART_CODE;
         end else if (RD_ADDR_IN == `BGSR_ADDR_OP_STATE) begin
            RD_DATA_OUT <= {overrun, gate_cnt, op_state};
         end else begin
            RD_DATA_OUT <= 8'h00;          // Unmapped reads zero
         end
      end
   end
endmodule // bgsr_status_regs

// >>> bgsr_consts.vh
// Constants for the buffer gate status register group
`ifndef BGSR_CONSTS_VH
`define BGSR_CONSTS_VH
`define BGSR_ADDR_X_FIRST   8'h0c
`define BGSR_ADDR_X_SECOND  8'h0d
`define BGSR_ADDR_Y_FIRST   8'h0e
`define BGSR_ADDR_Y_SECOND  8'h0f
`define BGSR_ADDR_Z_FIRST   8'h10
`define BGSR_ADDR_Z_SECOND  8'h11
`define BGSR_ADDR_REVISION  8'h12
`define BGSR_ADDR_PART_ID   8'h13
`define BGSR_ADDR_OP_STATE  8'h14
`define BGSR_OVERRUN_BIT    7
`define BGSR_MODE_STANDBY   2'h0
`define BGSR_MODE_WAKE      2'h1
`define BGSR_MODE_SLEEP     2'h2
`define BGSR_MODE_TRIGGER   2'h3
`define BGSR_BUF_OFF        2'h0
`define BGSR_REV_MAJOR      4'h2  // Arbitrary revision digits
`define BGSR_REV_MINOR      4'h3  // Arbitrary revision digits
`define BGSR_PART_CODE      8'h5a // Arbitrary part code
`define BGSR_DEPTH          32
`define BGSR_CNT_W          6
`endif

// >>> bgsr_sample_mem.v
// Sample memory holding 36-bit XYZ triplets, registered read data
`timescale 1ns/1ns
module bgsr_sample_mem #(
   parameter DEPTH = 32,                  // Number of triplets
   parameter AW    = 5,                   // Address width
   parameter DW    = 36                   // Triplet width
) (
   input  wire          clk_in,           // System clock
   input  wire          wr_en_in,         // Write strobe
   input  wire [AW-1:0] wr_addr_in,       // Write address
   input  wire [DW-1:0] wr_data_in,       // Write data
   input  wire [AW-1:0] rd_addr_in,       // Read address
   output reg  [DW-1:0] rd_data_out       // Registered read data
);
   reg [DW-1:0] mem [0:DEPTH-1];          // Storage array

   // Write port and registered read port
   always @(posedge clk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem[rd_addr_in];
   end
endmodule // bgsr_sample_mem

// >>> bgsr_status_asserts.sv
// Concurrent checks on the status register group ports
`timescale 1ns/1ns
module bgsr_status_asserts (
   input wire logic       SYS_CLK_IN,           // System clock
   input wire logic       NRST_IN,              // Reset, active low
   input wire logic       BYTE_ORDER_SELECT_IN, // Big-endian select
   input wire logic [1:0] BUF_MODE_IN,          // Buffer mode
   input wire logic       FLUSH_IN,             // Flush pulse
   input wire logic       RD_EN_IN,             // Read strobe
   input wire logic [7:0] RD_ADDR_IN,           // Read address
   input wire logic       WR_EN_IN,             // Write strobe
   input wire logic [7:0] RD_DATA_OUT,          // Read data
   input wire logic       RD_VALID_OUT,         // Read valid
   input wire logic [5:0] FILL_OUT              // Fill level
);
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!NRST_IN);
   a_rev_value: assert property (RD_EN_IN && RD_ADDR_IN == 8'h12 |=> RD_DATA_OUT == 8'h23)
      else $error("revision read wrong");
   a_part_code: assert property (RD_EN_IN && RD_ADDR_IN == 8'h13 |=> RD_DATA_OUT == 8'h5a)
      else $error("part code read wrong");
   a_be_nibble_zero: assert property (RD_EN_IN && BYTE_ORDER_SELECT_IN &&
      RD_ADDR_IN inside {8'h0d, 8'h0f, 8'h11} |=> RD_DATA_OUT[3:0] == 4'h0)
      else $error("second byte low nibble not zero");
   a_flag_when_empty: assert property (RD_EN_IN && RD_ADDR_IN == 8'h14 &&
      FILL_OUT == 6'h00 && $past(FILL_OUT) == 6'h00 |=> !RD_DATA_OUT[7])
      else $error("overrun flag set with empty buffer");
   a_count_when_empty: assert property (RD_EN_IN && RD_ADDR_IN == 8'h14 &&
      FILL_OUT == 6'h00 && $past(FILL_OUT) == 6'h00 ##1 1'b1 |-> RD_DATA_OUT[6:2] == 5'h00)
      else $error("period count nonzero with empty buffer");
   a_off_empties: assert property (BUF_MODE_IN == 2'h0 &&
      $past(BUF_MODE_IN) == 2'h0 |-> FILL_OUT == 6'h00)
      else $error("buffer not empty while off");
   a_flush_empties: assert property (FLUSH_IN |=> FILL_OUT == 6'h00)
      else $error("flush left samples");
   a_write_ignored: assert property (WR_EN_IN && !RD_EN_IN |=> !RD_VALID_OUT)
      else $error("write produced a read answer");
endmodule // bgsr_status_asserts
bind bgsr_status_regs bgsr_status_asserts i_bgsr_status_asserts (.*);

// >>> bgsr_host_model.sv
// Host model issuing register reads
`timescale 1ns/1ns
module bgsr_host_model (
   input  wire logic       clk_in,      // System clock
   input  wire logic       valid_in,    // Read valid pulse
   input  wire logic [7:0] data_in,     // Read data
   output logic            rd_en_out,   // Read strobe
   output logic [7:0]      rd_addr_out  // Read address
);
   initial begin
      rd_en_out = 1'b0;
      rd_addr_out = 8'h00;
   end
   // One read: strobe held for one cycle only, address inverted after release; valid awaited up to 4 edges
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
      ok = 1'b0;
      d = 8'h00;
      @(posedge clk_in);
      rd_en_out <= 1'b1;
      rd_addr_out <= a;
      for (int i = 0; i < 4 && !ok; i++) begin
         @(posedge clk_in);
         rd_en_out <= 1'b0;
         rd_addr_out <= ~a;
         #1;
         if (valid_in === 1'b1) begin
            ok = 1'b1;
            d = data_in;
         end
      end
   endtask
endmodule // bgsr_host_model

// >>> tb_bgsr_status_regs.sv
// Testbench for the status register group
`timescale 1ns/1ns
module tb_bgsr_status_regs;
   logic clk = 0, nrst = 0, strap = 0, be = 0, lifo = 0, gate = 0, flush = 0, mv = 0, sv = 0;
   logic rd_en, pop = 0, wr = 0, rv;
   logic [1:0] bm = 2'h0, mreq = 2'h0;
   logic [11:0] sx = 12'h000, sy = 12'h000, sz = 12'h000;
   logic [7:0] ra, rd, wa = 8'h00;
   logic [5:0] fill;
   int fails = 0, checks_done = 0;
   logic [7:0] e [6] = '{8'hab, 8'h30, 8'h80, 8'h10, 8'h07, 8'hf0};
   bgsr_status_regs i_bgsr_status_regs (.SYS_CLK_IN(clk), .NRST_IN(nrst),
      .BOOT_STATE_PIN_IN(strap), .BYTE_ORDER_SELECT_IN(be), .LIFO_ORDER_IN(lifo),
      .GATE_ENABLE_IN(gate), .BUF_MODE_IN(bm), .FLUSH_IN(flush), .MODE_REQ_IN(mreq),
      .MODE_REQ_VALID_IN(mv), .SAMPLE_VALID_IN(sv), .SAMPLE_X_IN(sx), .SAMPLE_Y_IN(sy),
      .SAMPLE_Z_IN(sz), .RD_EN_IN(rd_en), .RD_ADDR_IN(ra), .POP_IN(pop), .WR_EN_IN(wr),
      .WR_ADDR_IN(wa), .WR_DATA_IN(8'hff), .RD_DATA_OUT(rd), .RD_VALID_OUT(rv),
      .FILL_OUT(fill));
   bgsr_host_model i_bgsr_host_model (.clk_in(clk), .valid_in(rv), .data_in(rd),
      .rd_en_out(rd_en), .rd_addr_out(ra));
   initial forever #50 clk = ~clk;
   // Compare and count
   task automatic chk(input logic [7:0] g, input logic [7:0] x);
      checks_done++;
      if (g !== x) begin
         fails++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, x);
      end
   endtask
   // Read a register and compare
   task automatic rc(input logic [7:0] a, input logic [7:0] x);
      logic [7:0] d;
      bit ok;
      i_bgsr_host_model.rd(a, d, ok);
      if (!ok) begin
         fails++;
         $display("[FAIL] t=%0t read timeout got %h exp %h", $time, d, x);
         results();
      end
      chk(d, x);
   endtask
   // One-cycle pulse helper: 0 sample, 1 pop, 2 flush, 3 mode request, 4 write
   task automatic pulse(input int k);
      @(posedge clk);
      {sv, pop, flush, mv, wr} <= 5'h10 >> k;
      @(posedge clk);
      {sv, pop, flush, mv, wr} <= 5'h00;
      repeat (2) @(posedge clk);
   endtask
   task automatic results;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      for (int s = 0; s < 2; s++) begin
         nrst <= 1'b0;
         strap <= s[0];
         repeat (12) @(posedge clk);
         nrst <= 1'b1;
         repeat (2) @(posedge clk);
         rc(8'h14, {7'h00, s[0]});
      end
      rc(8'h12, 8'h23);
      wa <= 8'h13;
      pulse(4);
      rc(8'h13, 8'h5a);
      rc(8'h15, 8'h00);
      foreach (e[m]) if (m < 4) begin
         mreq <= 2'(m ^ 1);
         pulse(3);
         rc(8'h14, 8'(m ^ 1));
      end
      mreq <= 2'h1;
      pulse(3);
      bm <= 2'h1;
      be <= 1'b1;
      {sx, sy, sz} <= {12'hab3, 12'h801, 12'h07f};
      pulse(0);
      sx <= 12'h125;
      pulse(0);
      chk({2'h0, fill}, 8'h02);
      for (int i = 0; i < 6; i++) rc(8'h0c + 8'(i), e[i]);
      lifo <= 1'b1;
      rc(8'h0c, 8'h12);
      rc(8'h0d, 8'h50);
      lifo <= 1'b0;
      be <= 1'b0;
      rc(8'h0c, 8'hb3);
      rc(8'h0d, 8'hfa);
      gate <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         if (k > 0) pulse(0);
         pulse(0);
         rc(8'h14, 8'h81);
         pulse(0);
         rc(8'h14, 8'h85);
         chk({2'h0, fill}, k > 0 ? 8'h01 : 8'h02);
         if (k == 0) repeat (2) pulse(1);
         if (k == 1) pulse(2);
         if (k == 2) begin
            bm <= 2'h0;
            repeat (3) @(posedge clk);
            bm <= 2'h1;
         end
         if (k == 3) begin
            mreq <= 2'h0;
            pulse(3);
            mreq <= 2'h1;
            pulse(3);
         end
         chk({2'h0, fill}, 8'h00);
         rc(8'h14, 8'h01);
      end
      results();
   end
endmodule // tb_bgsr_status_regs
